// ### rtl/clkgen_defs.svh
`ifndef CLKGEN_DEFS_SVH
`define CLKGEN_DEFS_SVH

// oscillator falls after a warm request before pins go to reset state
`define CLKGEN_WARM_FALLS        3'd2
// processor clock held low for this many oscillator periods on realignment
`define CLKGEN_REALIGN_PERIODS   3'd2
// processor clock falling edges after realignment before reset indication drops
`define CLKGEN_RESET_INDICATION_OUT_CLK_FALLS  3'd2
// processor clock periods from request release to first bus activity
`define CLKGEN_BUS_START_PERIODS 5'd7
// oscillator falls per processor clock period
`define CLKGEN_FALLS_PER_PERIOD  5'd2
// reset values
`define CLKGEN_RST_CLK           1'b0
`define CLKGEN_RST_RESET_IND     1'b1

`endif

// ### rtl/clkgen_pkg.sv
package clkgen_pkg;
   typedef enum logic [1:0] {
      ST_RESET,
      ST_REALIGN,
      ST_RELEASE,
      ST_RUN
   } seq_state_e;
endpackage

// ### rtl/clock_divider_reset_sync.sv
// Behaviour
// - processor clock is oscillator divided by two
// - processor clock toggles on oscillator falling edge
// - clock runs in reset, hold, idle; stops powerdown
// - reset derived from request, synchronised to clock
// - cold reset pins reach reset within 28
// - warm reset at second oscillator fall after request
// - request sampled on each oscillator falling edge
// - request rise makes phase realignment pulse
// - clock high at rise: hold clock low
// - clock low at rise: clock left alone
// - reset indication drops second clock fall later
// - bus starts seven processor periods after rise
// - hold during reset acknowledged at once, no fetch
// - hold acknowledged when bus idle, dropped on release
`timescale 1ns/1ps
`include "clkgen_defs.svh"
module clock_divider_reset_sync (
   // clock and reset
   input  wire logic sys_clk,
   input  wire logic rstn,
   // oscillator and reset pins
   input  wire logic osc_input_clock,
   input  wire logic reset_request_in,
   // bus hold pins
   input  wire logic hold_request_in,
   output logic      bus_grant_ack,
   // core side, same clock
   input  wire logic powerdown_in,
   input  wire logic bus_idle_in,
   // generated outputs
   output logic      processor_clock_out,
   output logic      reset_indication_out,
   output logic      phase_realign_pulse,
   output logic      bus_start_out,
   output logic      fetch_enable
);
   divider_if dv ();

   // pin synchronisers; the first stage feeds only the second
   logic [1:0] osc_sync_q;
   logic [1:0] req_sync_q;
   logic [1:0] hold_sync_q;
   logic       osc_prev_q;

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         osc_sync_q  <= 2'h0;
         req_sync_q  <= 2'h0;
         hold_sync_q <= 2'h0;
         osc_prev_q  <= 1'b0;
      end else begin
         osc_sync_q  <= {osc_sync_q[0], osc_input_clock};
         req_sync_q  <= {req_sync_q[0], reset_request_in};
         hold_sync_q <= {hold_sync_q[0], hold_request_in};
         osc_prev_q  <= osc_sync_q[1];
      end
   end

   logic osc_fall;
   assign osc_fall = osc_prev_q & ~osc_sync_q[1];

   // sequencer state
   clkgen_pkg::seq_state_e st_q, st_d;
   logic       req_smp_q, req_smp_d;
   logic [2:0] warm_cnt_q, warm_cnt_d;
   logic [2:0] align_cnt_q, align_cnt_d;
   logic [2:0] rel_cnt_q, rel_cnt_d;
   logic [4:0] bus_cnt_q, bus_cnt_d;
   logic       bus_start_q, bus_start_d;
   logic       rst_ind_q, rst_ind_d;
   logic       pulse_q, pulse_d;
   logic       grant_q, grant_d;

   always_comb begin
      st_d        = st_q;
      req_smp_d   = req_smp_q;
      warm_cnt_d  = warm_cnt_q;
      align_cnt_d = align_cnt_q;
      rel_cnt_d   = rel_cnt_q;
      bus_cnt_d   = bus_cnt_q;
      bus_start_d = bus_start_q;
      rst_ind_d   = rst_ind_q;
      pulse_d     = 1'b0;
      if (osc_fall) begin
         req_smp_d = req_sync_q[1];
         if (align_cnt_q != 3'd0) begin
            align_cnt_d = align_cnt_q - 3'd1;
         end
         if (!req_sync_q[1]) begin
            // a held request keeps everything in reset and forgets any realignment
            align_cnt_d = 3'd0;
            rel_cnt_d   = 3'd0;
            bus_cnt_d   = 5'd0;
            bus_start_d = 1'b0;
            if (st_q == clkgen_pkg::ST_RUN) begin
               // warm reset: count falls so a short glitch cannot raise reset indication in a running part, though it still clears bus start
               warm_cnt_d = warm_cnt_q + 3'd1;
               if (warm_cnt_d >= `CLKGEN_WARM_FALLS) begin
                  st_d       = clkgen_pkg::ST_RESET;
                  rst_ind_d  = 1'b1;
                  warm_cnt_d = 3'd0;
               end
            end else begin
               st_d      = clkgen_pkg::ST_RESET;
               rst_ind_d = 1'b1;
            end
         end else begin
            warm_cnt_d = 3'd0;
            if (bus_cnt_q != 5'd0 && !bus_start_q) begin
               bus_cnt_d = bus_cnt_q + 5'd1;
               if (bus_cnt_d == `CLKGEN_BUS_START_PERIODS * `CLKGEN_FALLS_PER_PERIOD) begin
                  bus_start_d = 1'b1;
               end
            end
            if (st_q == clkgen_pkg::ST_RESET && !req_smp_q) begin
               pulse_d   = 1'b1;
               bus_cnt_d = 5'd1;
               rel_cnt_d = 3'd0;
               if (dv.clk_level) begin
                  // this fall drops the clock; the next fall keeps it low
                  align_cnt_d = `CLKGEN_REALIGN_PERIODS - 3'd1;
                  st_d        = clkgen_pkg::ST_REALIGN;
               end else begin
                  st_d = clkgen_pkg::ST_RELEASE;
               end
            end else if (st_q == clkgen_pkg::ST_REALIGN && align_cnt_q == 3'd0) begin
               st_d = clkgen_pkg::ST_RELEASE;
            end
         end
      end
      if (st_q == clkgen_pkg::ST_RELEASE && dv.clk_fall && req_sync_q[1]) begin
         rel_cnt_d = rel_cnt_q + 3'd1;
         if (rel_cnt_d == `CLKGEN_RESET_INDICATION_OUT_CLK_FALLS) begin
            rst_ind_d = 1'b0;
            st_d      = clkgen_pkg::ST_RUN;
         end
      end
   end

   // hold handshake: in reset there is no bus cycle to finish
   always_comb begin
      grant_d = grant_q;
      if (!hold_sync_q[1]) begin
         grant_d = 1'b0;
      end else if (rst_ind_q || !bus_start_q) begin
         grant_d = 1'b1;
      end else if (bus_idle_in) begin
         grant_d = 1'b1;
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         st_q        <= clkgen_pkg::ST_RESET;
         req_smp_q   <= 1'b0;
         warm_cnt_q  <= 3'd0;
         align_cnt_q <= 3'd0;
         rel_cnt_q   <= 3'd0;
         bus_cnt_q   <= 5'd0;
         bus_start_q <= 1'b0;
         rst_ind_q   <= `CLKGEN_RST_RESET_IND;
         pulse_q     <= 1'b0;
         grant_q     <= 1'b0;
      end else begin
         st_q        <= st_d;
         req_smp_q   <= req_smp_d;
         warm_cnt_q  <= warm_cnt_d;
         align_cnt_q <= align_cnt_d;
         rel_cnt_q   <= rel_cnt_d;
         bus_cnt_q   <= bus_cnt_d;
         bus_start_q <= bus_start_d;
         rst_ind_q   <= rst_ind_d;
         pulse_q     <= pulse_d;
         grant_q     <= grant_d;
      end
   end

   // divider keeps running through reset and hold, only powerdown stops it
   assign dv.osc_fall  = osc_fall;
   assign dv.run       = ~powerdown_in;
   assign dv.force_low = (align_cnt_q != 3'd0);

   phase_divider u_div (
      .sys_clk (sys_clk),
      .rstn    (rstn),
      .dv      (dv.div)
   );

   assign processor_clock_out  = dv.clk_level;
   assign reset_indication_out = rst_ind_q;
   assign phase_realign_pulse  = pulse_q;
   assign bus_start_out        = bus_start_q;
   assign bus_grant_ack        = grant_q;
   // no fetch while granted away or before bus start
   assign fetch_enable         = bus_start_q & ~grant_q & ~rst_ind_q;
endmodule

// ### rtl/divider_if.sv
`timescale 1ns/1ps
interface divider_if;
   logic osc_fall;
   logic run;
   logic force_low;
   logic clk_level;
   logic clk_fall;

   modport ctrl (output osc_fall, output run, output force_low, input clk_level, input clk_fall);
   modport div  (input osc_fall, input run, input force_low, output clk_level, output clk_fall);
endinterface

// ### rtl/phase_divider.sv
`timescale 1ns/1ps
`include "clkgen_defs.svh"
module phase_divider (
   // clock and reset
   input  wire logic sys_clk,
   input  wire logic rstn,
   // control from the sequencer
   divider_if.div    dv
);
   logic clk_q;
   logic clk_d;

   // every change happens only on an oscillator falling edge
   always_comb begin
      clk_d = clk_q;
      if (dv.osc_fall && dv.run) begin
         if (dv.force_low) begin
            clk_d = 1'b0;
         end else begin
            clk_d = ~clk_q;
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         clk_q <= `CLKGEN_RST_CLK;
      end else begin
         clk_q <= clk_d;
      end
   end

   assign dv.clk_level = clk_q;
   assign dv.clk_fall  = clk_q & ~clk_d;
endmodule

// ### tb/board_model.sv
`timescale 1ns/1ps
module board_model (
   // clock
   input  wire logic sys_clk,
   // pins toward the device
   output logic      osc_input_clock,
   output logic      reset_request_in,
   output logic      hold_request_in
);
   // free-running oscillator, 80 ns, slow enough for the pin synchroniser
   initial osc_input_clock = 1'b0;
   always #40 osc_input_clock = ~osc_input_clock;
   initial reset_request_in = 1'b0; // low from power-up
   initial hold_request_in = 1'b0;
   // callers keep the request low long enough
   task automatic set_req(input logic v);
      @(posedge sys_clk);
      reset_request_in <= v;
   endtask
   task automatic set_hold(input logic v);
      @(posedge sys_clk);
      hold_request_in <= v;
   endtask
endmodule

// ### tb/clkgen_sva.sv
`timescale 1ns/1ps
module clkgen_sva (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rstn,
   // pins and core side
   input wire logic osc_input_clock,
   input wire logic reset_request_in,
   input wire logic hold_request_in,
   input wire logic bus_grant_ack,
   input wire logic powerdown_in,
   input wire logic bus_idle_in,
   // generated outputs
   input wire logic processor_clock_out,
   input wire logic reset_indication_out,
   input wire logic phase_realign_pulse,
   input wire logic bus_start_out,
   input wire logic fetch_enable
);
   logic o1_q, o2_q, o3_q, h1_q, h2_q;
   logic osc_fall;
   // own copy of the oscillator and hold synchronisers, so checks do not lean on the design
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         {o1_q, o2_q, o3_q, h1_q, h2_q} <= '0;
      end else begin
         {o1_q, o2_q, o3_q, h1_q, h2_q} <= {osc_input_clock, o1_q, o2_q, hold_request_in, h1_q};
      end
   end
   assign osc_fall = o3_q & ~o2_q;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rstn);
   property p_tog;
      $changed(processor_clock_out) |-> $past(osc_fall) || $past(osc_fall, 2) || $past(osc_fall, 3);
   endproperty
   a_tog: assert property (p_tog) else $error("clock moved off an oscillator fall");
   property p_pd;
      powerdown_in [*3] |-> $stable(processor_clock_out);
   endproperty
   a_pd: assert property (p_pd) else $error("clock moved in powerdown");
   property p_fetch;
      fetch_enable |-> bus_start_out && !bus_grant_ack && !reset_indication_out;
   endproperty
   a_fetch: assert property (p_fetch) else $error("fetch while held or in reset");
   property p_grant;
      h2_q && reset_indication_out |-> ##[1:2] bus_grant_ack;
   endproperty
   a_grant: assert property (p_grant) else $error("hold in reset not granted");
   property p_drop;
      !h2_q [*3] |-> !bus_grant_ack;
   endproperty
   a_drop: assert property (p_drop) else $error("grant kept without hold");
   property p_pulse;
      phase_realign_pulse |=> !phase_realign_pulse;
   endproperty
   a_pulse: assert property (p_pulse) else $error("realign pulse too long");
   property p_pulse_rst;
      phase_realign_pulse |-> reset_indication_out;
   endproperty
   a_pulse_rst: assert property (p_pulse_rst) else $error("realign outside reset");
   property p_rel;
      $fell(reset_indication_out) |-> reset_request_in;
   endproperty
   a_rel: assert property (p_rel) else $error("indication dropped with request low");
   property p_start;
      $rose(bus_start_out) |-> !reset_indication_out && reset_request_in;
   endproperty
   a_start: assert property (p_start) else $error("bus started in reset");
   property p_idle;
      $rose(bus_grant_ack) && $past(bus_start_out) && !$past(reset_indication_out) |-> $past(bus_idle_in);
   endproperty
   a_idle: assert property (p_idle) else $error("grant given during a bus cycle");
   c_realign: cover property (phase_realign_pulse);
   c_release: cover property ($fell(reset_indication_out));
   c_grant: cover property (bus_grant_ack);
   c_start: cover property ($rose(bus_start_out));
endmodule

bind clock_divider_reset_sync clkgen_sva clkgen_sva_i (.sys_clk, .rstn, .osc_input_clock, .reset_request_in,
   .hold_request_in, .bus_grant_ack, .powerdown_in, .bus_idle_in, .processor_clock_out,
   .reset_indication_out, .phase_realign_pulse, .bus_start_out, .fetch_enable);

// ### tb/tb_top.sv
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin err_count++; $display("FAIL %0t got %b", $time, (a)); end end
module tb_top;
   logic sys_clk, rstn, powerdown_in, bus_idle_in, osc_input_clock, reset_request_in, hold_request_in;
   logic bus_grant_ack, processor_clock_out, reset_indication_out, phase_realign_pulse, bus_start_out;
   logic fetch_enable;
   int   err_count, checks, cyc;
   board_model board_model_i (.sys_clk, .osc_input_clock, .reset_request_in, .hold_request_in);
   clock_divider_reset_sync clock_divider_reset_sync_i (.sys_clk, .rstn, .osc_input_clock,
      .reset_request_in, .hold_request_in, .bus_grant_ack, .powerdown_in, .bus_idle_in,
      .processor_clock_out, .reset_indication_out, .phase_realign_pulse, .bus_start_out, .fetch_enable);
   initial sys_clk = 1'b0;
   always #5 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 5000) begin
         err_count++;
         report_and_stop();
      end
   end
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic waitn(input int n);
      repeat (n) @(negedge sys_clk);
   endtask
   task automatic t_cold();
      int   k, kr;
      logic seen;
      waitn(224);
      `CHK(reset_indication_out, 1'b1)
      board_model_i.set_req(1'b1);
      seen = 1'b0;
      kr = 0;
      for (k = 0; k < 200 && bus_start_out !== 1'b1; k++) begin
         @(negedge sys_clk);
         seen |= phase_realign_pulse;
         if (reset_indication_out !== 1'b0) kr = k;
      end
      `CHK(seen, 1'b1)
      `CHK(kr < 64, 1'b1)
      `CHK(k >= 104 && k <= 124, 1'b1)
      `CHK(fetch_enable, 1'b1)
      $display("test cold done");
   endtask
   task automatic t_clock();
      int   hi, tg;
      logic last;
      hi = 0;
      tg = 0;
      last = processor_clock_out;
      repeat (32) begin
         @(negedge sys_clk);
         hi += processor_clock_out;
         tg += (processor_clock_out !== last);
         last = processor_clock_out;
      end
      `CHK(hi == 16, 1'b1)
      `CHK(tg == 4, 1'b1)
      $display("test clock done");
   endtask
   task automatic t_pd();
      int   n;
      logic v;
      @(posedge sys_clk) powerdown_in <= 1'b1;
      waitn(4);
      v = processor_clock_out;
      n = 0;
      repeat (40) begin
         @(negedge sys_clk);
         n += (processor_clock_out !== v);
      end
      `CHK(n == 0, 1'b1)
      @(posedge sys_clk) powerdown_in <= 1'b0;
      $display("test powerdown done");
   endtask
   task automatic t_hold_run();
      @(posedge sys_clk) bus_idle_in <= 1'b0;
      board_model_i.set_hold(1'b1);
      waitn(8);
      `CHK(bus_grant_ack, 1'b0)
      @(posedge sys_clk) bus_idle_in <= 1'b1;
      waitn(4);
      `CHK(bus_grant_ack, 1'b1)
      `CHK(fetch_enable, 1'b0)
      board_model_i.set_hold(1'b0);
      waitn(5);
      `CHK(bus_grant_ack, 1'b0)
      $display("test hold done");
   endtask
   task automatic t_warm();
      board_model_i.set_req(1'b0);
      waitn(5);
      board_model_i.set_req(1'b1);
      waitn(40);
      `CHK(reset_indication_out, 1'b0)
      board_model_i.set_req(1'b0);
      board_model_i.set_hold(1'b1);
      waitn(24);
      `CHK(reset_indication_out, 1'b1)
      `CHK(bus_grant_ack, 1'b1)
      `CHK(fetch_enable, 1'b0)
      t_clock();
      board_model_i.set_hold(1'b0);
      board_model_i.set_req(1'b1);
      waitn(80);
      `CHK(reset_indication_out, 1'b0)
      $display("test warm done");
   endtask
   initial begin
      rstn = 1'b0;
      powerdown_in = 1'b0;
      bus_idle_in = 1'b1;
      repeat (5) @(posedge sys_clk);
      rstn <= 1'b1;
      t_cold();
      t_clock();
      t_pd();
      t_clock();
      t_hold_run();
      t_warm();
      report_and_stop();
   end
endmodule
